// File: bench/lcs_link_regs_checker.sv
// Assertions on the link register bank ports
`timescale 1ns/1ns
`default_nettype none

module lcs_link_regs_checker #(
	parameter int RETRAIN_DELAY_CYC = 20
) (
	// Clock, reset, register port
	input wire logic              clock_i,
	input wire logic              rst_n_i,
	input wire logic [7:0]        addr_i,
	input wire logic [15:0]       wdata_i,
	input wire logic              wr_i,
	input wire logic              rd_i,
	input wire logic [15:0]       rdata_o,
	// Port side
	input wire logic              upstream_i,
	input wire lcs_pkg::lcs_cap_t cap_i,
	input wire lcs_pkg::lcs_phy_t phy_i,
	input wire logic              retrain_go_o,
	input wire logic              bw_irq_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	localparam int UP_MAX = RETRAIN_DELAY_CYC + 4;
	logic rd_c;
	logic rd_s;
	logic go_q;
	logic in_l0;
	assign rd_c  = rd_i && addr_i == lcs_pkg::LINK_CONTROL_IDX;
	assign rd_s  = rd_i && addr_i == lcs_pkg::LINK_STATUS_IDX;
	assign go_q  = wr_i && addr_i == lcs_pkg::LINK_CONTROL_IDX
		&& wdata_i[lcs_pkg::CTL_RETRAIN_BIT];
	assign in_l0 = phy_i.ltssm == lcs_pkg::LCS_LTSSM_L0;

	chk_ctl_zeros: assert property (rd_c |=> (rdata_o & 16'hF320) == 16'h0000)
		else $error("control zero bits set");
	chk_training_error_zero: assert property (rd_s |=> !rdata_o[10])
		else $error("training error set");
	chk_speed_legal: assert property (rd_s |=> rdata_o[3:0] inside {4'h1, 4'h2})
		else $error("speed code illegal");
	chk_dll_cap: assert property (rd_s && !cap_i.dll_active_capable |=> !rdata_o[13])
		else $error("link active without capability");
	chk_irq_hw_zero: assert property (upstream_i || !cap_i.bw_notify_capable |-> !bw_irq_o)
		else $error("interrupt while hardwired off");
	chk_go_single: assert property (retrain_go_o |=> !retrain_go_o)
		else $error("retrain pulse too long");
	chk_go_down: assert property (go_q && !upstream_i && in_l0 |-> ##[1:3] retrain_go_o)
		else $error("downstream retrain missing");
	chk_go_up_wait: assert property (go_q && upstream_i |=> !retrain_go_o [*8])
		else $error("upstream retrain too early");
	chk_go_up_due: assert property (go_q && upstream_i && in_l0 |-> ##[1:UP_MAX] retrain_go_o)
		else $error("upstream retrain missing");
	chk_irq_hold: assert property (bw_irq_o && !wr_i && $stable(cap_i) |=> bw_irq_o)
		else $error("interrupt dropped on its own");

	cov_go: cover property (retrain_go_o);
	cov_irq: cover property ($rose(bw_irq_o));
	cov_up: cover property (go_q && upstream_i);
endmodule : lcs_link_regs_checker

bind lcs_link_regs lcs_link_regs_checker #(.RETRAIN_DELAY_CYC(RETRAIN_DELAY_CYC)) i_chk (
	.clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
	.upstream_i, .cap_i, .phy_i, .retrain_go_o, .bw_irq_o
);

`default_nettype wire

// File: bench/lcs_phy_model.sv
// Behavioural physical layer that answers retrain requests
`timescale 1ns/1ns
`default_nettype none

module lcs_phy_model (
	// Clock and reset
	input  wire logic              clock_i,
	input  wire logic              rst_n_i,
	// Bench controls and block request
	input  wire lcs_pkg::lcs_phy_t base_i,
	input  wire logic              drop_i,
	input  wire logic              retrain_go_i,
	// Report to the block
	output var lcs_pkg::lcs_phy_t  phy_o
);
	lcs_pkg::lcs_ltssm_t ltssm_reg;
	logic [2:0]          cnt_reg;

	// ==========
	// Recovery held five cycles per request
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			ltssm_reg <= lcs_pkg::LCS_LTSSM_L0;
			cnt_reg   <= 3'h0;
		end else if (retrain_go_i) begin
			ltssm_reg <= lcs_pkg::LCS_LTSSM_RECOV;
			cnt_reg   <= 3'h5;
		end else if (cnt_reg != 3'h0) begin
			cnt_reg <= cnt_reg - 3'h1;
			if (cnt_reg == 3'h1) begin
				ltssm_reg <= lcs_pkg::LCS_LTSSM_L0;
			end
		end
	end

	always_comb begin
		phy_o         = base_i;
		phy_o.ltssm   = ltssm_reg;
		phy_o.dl_down = drop_i && cnt_reg == 3'h3;
	end
endmodule : lcs_phy_model

`default_nettype wire

// File: bench/tb_lcs_link_regs.sv
// Testbench for the link register bank
`timescale 1ns/1ns
`default_nettype none

module tb_lcs_link_regs;
	typedef struct packed {
		logic [3:0]  spd;
		logic [5:0]  w;
		logic        trn;
		logic        dll;
		logic [5:0]  max;
		logic [5:0]  sup;
		logic        dcap;
		logic [15:0] exp;
	} lcs_row_t;
	localparam logic [7:0] CTL = lcs_pkg::LINK_CONTROL_IDX;
	localparam logic [7:0] STS = lcs_pkg::LINK_STATUS_IDX;
	logic clock_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, upstream_i = 1'b0, drop = 1'b0;
	logic [7:0]        addr_i = 8'h00;
	logic [15:0]       wdata_i = 16'h0000;
	logic [15:0]       rdata_o;
	logic              retrain_go_o, bw_irq_o;
	lcs_pkg::lcs_cap_t cap_i = '{1'b1, 1'b1, 6'h20, 6'h3F};
	lcs_pkg::lcs_phy_t base = '0, phy;
	int                bad_count = 0, checked = 0, n;
	lcs_row_t rows [9] = '{
		'{4'h1, 6'h01, 1'b1, 1'b1, 6'h20, 6'h3F, 1'b1, 16'h2011},
		'{4'h2, 6'h02, 1'b1, 1'b0, 6'h20, 6'h3F, 1'b1, 16'h0022},
		'{4'h2, 6'h04, 1'b1, 1'b0, 6'h20, 6'h3F, 1'b1, 16'h0042},
		'{4'h1, 6'h08, 1'b1, 1'b1, 6'h20, 6'h3F, 1'b1, 16'h2081},
		'{4'h2, 6'h0C, 1'b1, 1'b1, 6'h20, 6'h3F, 1'b1, 16'h20C2},
		'{4'h1, 6'h10, 1'b1, 1'b0, 6'h20, 6'h3F, 1'b1, 16'h0101},
		'{4'h1, 6'h20, 1'b1, 1'b1, 6'h20, 6'h3F, 1'b0, 16'h0201},
		'{4'h1, 6'h04, 1'b1, 1'b0, 6'h10, 6'h0F, 1'b1, 16'h0101},
		'{4'h1, 6'h04, 1'b0, 1'b0, 6'h20, 6'h3F, 1'b1, 16'h0001}};

	always #5 clock_i = ~clock_i;

	lcs_link_regs #(.RETRAIN_DELAY_CYC(20)) i_lcs_link_regs (.clock_i, .rst_n_i, .addr_i,
		.wdata_i, .wr_i, .rd_i, .rdata_o, .upstream_i, .up_common_clock_strap_i(1'b0),
		.down_common_clock_strap_i(1'b1), .cap_i, .phy_i(phy), .retrain_go_o, .bw_irq_o);
	lcs_phy_model i_lcs_phy_model (.clock_i, .rst_n_i, .base_i(base), .drop_i(drop),
		.retrain_go_i(retrain_go_o), .phy_o(phy));

	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic chk(input string nm, input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge clock_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 cmp(nm, e, rdata_o & m);
	endtask : chk
	task automatic wait_go(output int c);
		c = 0;
		while (retrain_go_o !== 1'b1 && c < 200) begin
			@(posedge clock_i);
			#1 c++;
		end
	endtask : wait_go
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	initial begin
		#60000;
		bad_count++;
		stop_test;
	end

	initial begin
		base.speed = 4'h1;
		repeat (4) @(posedge clock_i);
		rst_n_i <= 1'b1;
		chk("control reset", CTL, 16'hFF20, 16'h0000);
		chk("status reset", STS, 16'hFFFF, 16'h1001);
		wr(CTL, 16'hFFDF);
		chk("control write", CTL, 16'hFF20, 16'h0C00);
		$display("test reset done");
		for (int i = 0; i < 9; i++) begin
			base.speed <= rows[i].spd;
			base.width <= rows[i].w;
			base.trained <= rows[i].trn;
			base.dll_up <= rows[i].dll;
			cap_i <= '{1'b1, rows[i].dcap, rows[i].max, rows[i].sup};
			repeat (2) @(posedge clock_i);
			chk("status row", STS, 16'h23FF, rows[i].exp);
		end
		$display("test table done");
		wr(CTL, 16'h0C20);
		wait_go(n);
		cmp("retrain go", 16'h0001, 16'(n));
		chk("training flag", STS, 16'h0800, 16'h0800);
		repeat (8) @(posedge clock_i);
		chk("retrain end", STS, 16'hC800, 16'h4000);
		cmp("bw irq", 16'h0001, {15'h0, bw_irq_o});
		wr(STS, 16'h4000);
		#1 cmp("bw irq clear", 16'h0000, {15'h0, bw_irq_o});
		base.auto_change <= 1'b1;
		@(posedge clock_i);
		base.auto_change <= 1'b0;
		#1 cmp("auto irq", 16'h0001, {15'h0, bw_irq_o});
		chk("auto status", STS, 16'hC000, 16'h8000);
		wr(STS, 16'h8000);
		#1 cmp("auto irq clear", 16'h0000, {15'h0, bw_irq_o});
		@(posedge clock_i);
		addr_i             <= STS;
		wdata_i            <= 16'h4000;
		wr_i               <= 1'b1;
		base.reliab_change <= 1'b1;
		@(posedge clock_i);
		wr_i               <= 1'b0;
		base.reliab_change <= 1'b0;
		chk("set beats clear", STS, 16'h4000, 16'h4000);
		wr(STS, 16'h4000);
		chk("late clear", STS, 16'h4000, 16'h0000);
		$display("test retrain done");
		drop <= 1'b1;
		wr(CTL, 16'h0C20);
		wait_go(n);
		cmp("retrain go again", 16'h0001, 16'(n));
		repeat (8) @(posedge clock_i);
		chk("retrain link down", STS, 16'h4800, 16'h0000);
		drop <= 1'b0;
		cap_i.bw_notify_capable <= 1'b0;
		wr(CTL, 16'h0C00);
		chk("not capable", CTL, 16'h0C00, 16'h0000);
		wr(lcs_pkg::STRAP_LOAD_IDX, 16'h0000);
		chk("slot clock load", STS, 16'h1000, 16'h0000);
		chk("unmapped", 8'h60, 16'hFFFF, 16'h0000);
		$display("test capability done");
		rst_n_i <= 1'b0;
		upstream_i <= 1'b1;
		cap_i.bw_notify_capable <= 1'b1;
		repeat (4) @(posedge clock_i);
		rst_n_i <= 1'b1;
		chk("upstream strap", STS, 16'h1000, 16'h0000);
		wr(CTL, 16'h0C00);
		chk("upstream enables", CTL, 16'h0C00, 16'h0000);
		wr(CTL, 16'h0020);
		chk("upstream pending", STS, 16'h0800, 16'h0800);
		wait_go(n);
		cmp("upstream delay", 16'h0001, {15'h0, n >= 16 && n <= 22});
		$display("test upstream done");
		stop_test;
	end
endmodule : tb_lcs_link_regs

`default_nettype wire

// File: src/lcs_link_regs.sv
// Link control upper half and link status register bank of one switch port
//
// Behaviour
// - Clock power management enable reads zero; unsupported.
// - Autonomous width disable reads zero and has no effect.
// - Bandwidth management enable raises interrupt when its status bit sets.
// - Autonomous bandwidth enable raises interrupt when its status bit sets.
// - Both interrupt enables read zero when bandwidth notification is not capable.
// - Upstream port: both interrupt enables hardwired zero, writes ignored.
// - Current speed: 1 for 2.5 Gbps, 2 for 5 Gbps, resets to 1.
// - Negotiated width uses single-bit codes except x12, which is 001100b.
// - Unsupported maximum width setting is reported instead of the negotiated width.
// - Supported maximum width but link not trained: width reads zero.
// - Training error is read-only zero.
// - Training indicator set in Configuration, Recovery, or while retrain pends.
// - Upstream retrain takes effect after 1 ms; indicator stays set meanwhile.
// - Training indicator clears when the LTSSM leaves Configuration or Recovery.
// - Slot clock bit resets to the port's common-clock strap; EEPROM may override.
// - Data link active bit follows the data link state, resets to zero.
// - Data link active never set when its capability bit is clear.
// - Writing one to retrain sends LTSSM into Recovery; bit reads zero.
// - Bandwidth status set when requested retrain completes without DL_Down; W1C.
//
// The implementer's own choice: strobed register access.

`timescale 1ns/1ns
`default_nettype none

module lcs_link_regs #(
	parameter int RETRAIN_DELAY_CYC = lcs_pkg::RETRAIN_DELAY_CYC
) (
	// Clock and reset
	input  wire logic              clock_i,
	input  wire logic              rst_n_i,
	// Register port
	input  wire logic [7:0]        addr_i,
	input  wire logic [15:0]       wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [15:0]       rdata_o,
	// Port identity and straps
	input  wire logic              upstream_i,
	input  wire logic              up_common_clock_strap_i,
	input  wire logic              down_common_clock_strap_i,
	// Capabilities
	input  wire lcs_pkg::lcs_cap_t cap_i,
	// Physical and data link layer report
	input  wire lcs_pkg::lcs_phy_t phy_i,
	// Link control
	output logic                   retrain_go_o,
	output logic                   bw_irq_o
);

	// ==================== Checks
	if (RETRAIN_DELAY_CYC < 1 || RETRAIN_DELAY_CYC > 32'h00FFFFFF) begin : g_bad_delay
		$error("lcs_link_regs: retrain delay out of range");
	end

	// ==================== Decode
	logic wr_ctl;
	logic wr_sts;
	logic wr_strap;
	logic in_training;
	logic bw_allowed;
	assign wr_ctl      = wr_i && (addr_i == lcs_pkg::LINK_CONTROL_IDX);
	assign wr_sts      = wr_i && (addr_i == lcs_pkg::LINK_STATUS_IDX);
	assign wr_strap    = wr_i && (addr_i == lcs_pkg::STRAP_LOAD_IDX);
	assign in_training = (phy_i.ltssm == lcs_pkg::LCS_LTSSM_CONFIG)
		|| (phy_i.ltssm == lcs_pkg::LCS_LTSSM_RECOV);
	assign bw_allowed  = cap_i.bw_notify_capable && !upstream_i;

	// ==================== Interrupt enables
	logic bw_irq_en_reg;
	logic abw_irq_en_reg;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			bw_irq_en_reg  <= 1'b0;
			abw_irq_en_reg <= 1'b0;
		end else if (!bw_allowed) begin
			bw_irq_en_reg  <= 1'b0;
			abw_irq_en_reg <= 1'b0;
		end else if (wr_ctl) begin
			bw_irq_en_reg  <= wdata_i[lcs_pkg::CTL_BW_IRQ_BIT];
			abw_irq_en_reg <= wdata_i[lcs_pkg::CTL_ABW_IRQ_BIT];
		end
	end

	// ==================== Retrain request and upstream delay
	typedef enum logic [1:0] {
		LCS_RT_IDLE  = 2'b00,
		LCS_RT_DELAY = 2'b01,
		LCS_RT_GO    = 2'b10
	} lcs_retrain_t;

	logic         retrain_write;
	lcs_retrain_t rt_state_reg;
	logic [23:0]  delay_cnt_reg;
	logic         retrain_pending;
	assign retrain_write = wr_ctl && wdata_i[lcs_pkg::CTL_RETRAIN_BIT];

	// Retrain writes while a request is pending are absorbed
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			rt_state_reg  <= LCS_RT_IDLE;
			delay_cnt_reg <= 24'h000000;
		end else begin
			unique case (rt_state_reg)
				LCS_RT_IDLE: begin
					if (retrain_write) begin
						rt_state_reg  <= LCS_RT_DELAY;
						delay_cnt_reg <= upstream_i ? 24'(RETRAIN_DELAY_CYC - 1)
							: 24'h000000;
					end
				end
				LCS_RT_DELAY: begin
					if (delay_cnt_reg != 24'h000000) begin
						delay_cnt_reg <= delay_cnt_reg - 24'h000001;
					end else begin
						rt_state_reg <= LCS_RT_GO;
					end
				end
				LCS_RT_GO: begin
					rt_state_reg <= LCS_RT_IDLE;
				end
				default: begin
					rt_state_reg <= LCS_RT_IDLE;
				end
			endcase
		end
	end
	assign retrain_pending = (rt_state_reg != LCS_RT_IDLE);
	assign retrain_go_o    = (rt_state_reg == LCS_RT_GO);

	// ==================== Training indicator
	logic train_reg;
	logic await_train_reg;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			await_train_reg <= 1'b0;
		end else if (retrain_write) begin
			await_train_reg <= 1'b1;
		end else if (await_train_reg && in_training && !retrain_pending) begin
			await_train_reg <= 1'b0;
		end
	end
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			train_reg <= 1'b0;
		end else begin
			train_reg <= in_training || await_train_reg || retrain_write;
		end
	end

	// ==================== Retrain completion tracking
	logic sw_retrain_reg;
	logic was_training_reg;
	logic dl_down_seen_reg;
	logic retrain_done;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			was_training_reg <= 1'b0;
		end else begin
			was_training_reg <= in_training;
		end
	end
	assign retrain_done = sw_retrain_reg && !await_train_reg && was_training_reg
		&& !in_training;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sw_retrain_reg   <= 1'b0;
			dl_down_seen_reg <= 1'b0;
		end else if (retrain_write) begin
			sw_retrain_reg   <= 1'b1;
			dl_down_seen_reg <= 1'b0;
		end else if (retrain_done) begin
			sw_retrain_reg   <= 1'b0;
		end else if (sw_retrain_reg && phy_i.dl_down) begin
			dl_down_seen_reg <= 1'b1;
		end
	end

	// ==================== Bandwidth status bits, set wins over clear
	logic bw_sts_reg;
	logic abw_sts_reg;
	logic bw_set;
	logic abw_set;
	assign bw_set  = (retrain_done && !dl_down_seen_reg && !phy_i.dl_down)
		|| phy_i.reliab_change;
	assign abw_set = phy_i.auto_change;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || !bw_allowed) begin
			bw_sts_reg <= 1'b0;
		end else if (bw_set) begin
			bw_sts_reg <= 1'b1;
		end else if (wr_sts && wdata_i[lcs_pkg::STS_BW_BIT]) begin
			bw_sts_reg <= 1'b0;
		end
	end
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || !bw_allowed) begin
			abw_sts_reg <= 1'b0;
		end else if (abw_set) begin
			abw_sts_reg <= 1'b1;
		end else if (wr_sts && wdata_i[lcs_pkg::STS_ABW_BIT]) begin
			abw_sts_reg <= 1'b0;
		end
	end
	assign bw_irq_o = bw_allowed && ((bw_irq_en_reg && bw_sts_reg)
		|| (abw_irq_en_reg && abw_sts_reg));

	// ==================== Speed, width and data link state
	logic [3:0] speed_reg;
	logic [5:0] width_reg;
	logic       dll_reg;
	logic       max_supported;
	assign max_supported = |(cap_i.max_width_cap & cap_i.supported_widths);
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			speed_reg <= lcs_pkg::SPEED_RESET;
		end else if (phy_i.speed == lcs_pkg::SPEED_GEN1 || phy_i.speed == lcs_pkg::SPEED_GEN2) begin
			speed_reg <= phy_i.speed;
		end
	end
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			width_reg <= lcs_pkg::WIDTH_NONE;
		end else if (!max_supported) begin
			width_reg <= cap_i.max_width_cap;
		end else if (!phy_i.trained) begin
			width_reg <= lcs_pkg::WIDTH_NONE;
		end else begin
			unique case (phy_i.width)
				lcs_pkg::WIDTH_X1, lcs_pkg::WIDTH_X2, lcs_pkg::WIDTH_X4,
				lcs_pkg::WIDTH_X8, lcs_pkg::WIDTH_X12, lcs_pkg::WIDTH_X16,
				lcs_pkg::WIDTH_X32: begin
					width_reg <= phy_i.width;
				end
				default: begin
					width_reg <= lcs_pkg::WIDTH_NONE;
				end
			endcase
		end
	end
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			dll_reg <= 1'b0;
		end else begin
			dll_reg <= phy_i.dll_up && cap_i.dll_active_capable;
		end
	end

	// ==================== Slot clock configuration
	logic slot_clk_reg;
	logic strap_taken_reg;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			strap_taken_reg <= 1'b0;
			slot_clk_reg    <= 1'b0;
		end else if (!strap_taken_reg) begin
			strap_taken_reg <= 1'b1;
			slot_clk_reg    <= upstream_i ? up_common_clock_strap_i
				: down_common_clock_strap_i;
		end else if (wr_strap) begin
			slot_clk_reg <= wdata_i[lcs_pkg::STS_SLOT_CLK_BIT];
		end
	end

	// ==================== Read data
	logic [15:0] ctl_view;
	logic [15:0] sts_view;
	always_comb begin
		ctl_view = 16'h0000;
		ctl_view[lcs_pkg::CTL_BW_IRQ_BIT]  = bw_irq_en_reg && bw_allowed;
		ctl_view[lcs_pkg::CTL_ABW_IRQ_BIT] = abw_irq_en_reg && bw_allowed;
		sts_view = 16'h0000;
		sts_view[lcs_pkg::STS_SPEED_LSB +: 4] = speed_reg;
		sts_view[lcs_pkg::STS_WIDTH_LSB +: 6] = width_reg;
		sts_view[lcs_pkg::STS_TRAIN_BIT]      = train_reg;
		sts_view[lcs_pkg::STS_SLOT_CLK_BIT]   = slot_clk_reg;
		sts_view[lcs_pkg::STS_DLL_BIT]        = dll_reg;
		sts_view[lcs_pkg::STS_BW_BIT]         = bw_sts_reg;
		sts_view[lcs_pkg::STS_ABW_BIT]        = abw_sts_reg;
	end

	logic [15:0] rdata_reg;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			rdata_reg <= 16'h0000;
		end else if (rd_i) begin
			unique case (addr_i)
				lcs_pkg::LINK_CONTROL_IDX: begin
					rdata_reg <= ctl_view;
				end
				lcs_pkg::LINK_STATUS_IDX: begin
					rdata_reg <= sts_view;
				end
				lcs_pkg::STRAP_LOAD_IDX: begin
					rdata_reg <= {3'h0, slot_clk_reg, 12'h000};
				end
				default: begin
					rdata_reg <= 16'h0000;
				end
			endcase
		end else begin
			rdata_reg <= 16'h0000;
		end
	end
	assign rdata_o = rdata_reg;

endmodule : lcs_link_regs

`default_nettype wire

// File: src/lcs_pkg.sv
// Package for the link control and status register bank
package lcs_pkg;

	// ==================== Register map
	// Printed status offset is not a multiple of four: offsets are word indices
	localparam logic [7:0] LINK_CONTROL_IDX = 8'h51;
	localparam logic [7:0] LINK_STATUS_IDX  = 8'h52;
	localparam logic [7:0] STRAP_LOAD_IDX   = 8'h53;

	// ==================== Link control fields (upper half)
	localparam int CTL_RETRAIN_BIT   = 5;
	localparam int CTL_CLOCK_PM_BIT  = 8;
	localparam int CTL_AUTO_WIDTH_BIT = 9;
	localparam int CTL_BW_IRQ_BIT    = 10;
	localparam int CTL_ABW_IRQ_BIT   = 11;

	// ==================== Link status fields
	localparam int STS_SPEED_LSB     = 0;
	localparam int STS_WIDTH_LSB     = 4;
	localparam int STS_TRAINING_ERROR_BIT      = 10;
	localparam int STS_TRAIN_BIT     = 11;
	localparam int STS_SLOT_CLK_BIT  = 12;
	localparam int STS_DLL_BIT       = 13;
	localparam int STS_BW_BIT        = 14;
	localparam int STS_ABW_BIT       = 15;

	// ==================== Encodings and reset values
	localparam logic [3:0] SPEED_GEN1  = 4'h1;
	localparam logic [3:0] SPEED_GEN2  = 4'h2;
	localparam logic [3:0] SPEED_RESET = 4'h1;
	localparam logic [5:0] WIDTH_X1    = 6'h01;
	localparam logic [5:0] WIDTH_X2    = 6'h02;
	localparam logic [5:0] WIDTH_X4    = 6'h04;
	localparam logic [5:0] WIDTH_X8    = 6'h08;
	localparam logic [5:0] WIDTH_X12   = 6'h0C;
	localparam logic [5:0] WIDTH_X16   = 6'h10;
	localparam logic [5:0] WIDTH_X32   = 6'h20;
	localparam logic [5:0] WIDTH_NONE  = 6'h00;

	// ==================== Timing
	localparam int RETRAIN_DELAY_US = 1000;
	localparam int CLOCK_MHZ        = 100;
	localparam int RETRAIN_DELAY_CYC = RETRAIN_DELAY_US * CLOCK_MHZ;

	// ==================== LTSSM state groups seen by this block
	typedef enum logic [1:0] {
		LCS_LTSSM_OTHER  = 2'b00,
		LCS_LTSSM_CONFIG = 2'b01,
		LCS_LTSSM_RECOV  = 2'b10,
		LCS_LTSSM_L0     = 2'b11
	} lcs_ltssm_t;

	// ==================== Physical layer report
	typedef struct packed {
		lcs_ltssm_t  ltssm;
		logic [3:0]  speed;
		logic [5:0]  width;
		logic        trained;
		logic        dll_up;
		logic        dl_down;
		logic        auto_change;
		logic        reliab_change;
	} lcs_phy_t;

	// ==================== Capability fields
	typedef struct packed {
		logic        bw_notify_capable;
		logic        dll_active_capable;
		logic [5:0]  max_width_cap;
		logic [5:0]  supported_widths;
	} lcs_cap_t;

endpackage : lcs_pkg
